// *** rtl/pwcs_pkg.sv ***
// Purpose: Shared constants and carrier types for the PWM channel sequencer.
// Assumes: One 25 MHz clock; all period, width and delay counts are in time-base ticks.
// Notes: Configuration values are static while a sequence runs.
package pwcs_pkg;

  // Clock rate and time bases.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TB_FINE_NS = 100000;
  localparam int unsigned TB_COARSE_NS = 1000000;
  localparam int unsigned TICK_FINE_CYC = TB_FINE_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_COARSE_CYC = TB_COARSE_NS / CLK_PERIOD_NS;

  // Output value formats: full-scale values.
  localparam logic [15:0] PERMILLE_FULL = 16'h03e8;
  localparam logic [15:0] ANALOG_FULL = 16'h6c00;

  // Factors carry a weight of one tenth.
  localparam logic [7:0] FACTOR_DIV = 8'h0a;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] PERIOD_DEFAULT = 16'h4e20;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SYNC = 2'b10,
    ST_RUN = 2'b11
  } pwcs_state_e;

  // Static configuration of the channel.
  typedef struct packed {
    logic iso_mode;
    logic long_if;
    logic gate_input_role;
    logic time_base_coarse;
    logic fmt_analog;
    logic [15:0] period_param;
    logic [15:0] min_width;
    logic [15:0] on_delay_param;
    logic [15:0] bus_cycle_ticks;
  } pwcs_cfg_s;

  // Cyclic control data from the controller.
  typedef struct packed {
    logic sw_start_request;
    logic direct_override;
    logic [15:0] output_value;
    logic [7:0] period_factor;
    logic [15:0] period_setpoint;
    logic [7:0] on_delay_factor;
  } pwcs_ctrl_s;

  // Feedback to the controller and the actuator output.
  typedef struct packed {
    logic sequence_active_flag;
    logic start_request_echo;
    logic gate_level;
    logic pulse_out;
  } pwcs_stat_s;

endpackage

// *** rtl/pwcs_tick.sv ***
// Purpose: Time-base tick generator, one-cycle pulse per selected base.
// Assumes: The base selection is static while a sequence runs.
// Notes: Free-running, so the first tick of a sequence may come early by up to one base.
`timescale 1ns/10ps
`default_nettype none
module pwcs_tick #(
  parameter int unsigned FINE_CYC = 2500,
  parameter int unsigned COARSE_CYC = 25000
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Base selection and tick.
  input wire logic coarse_sel,
  output logic tick
);

  logic [15:0] div_reg;
  logic [15:0] div_next;
  wire [15:0] div_last = coarse_sel ? 16'(COARSE_CYC - 1) : 16'(FINE_CYC - 1);
  wire div_end = (div_reg >= div_last);

  // Counter restarts on its last count, so a base change takes effect at once.
  assign div_next = div_end ? 16'h0000 : div_reg + 16'h0001;
  assign tick = div_end;

  // Divider register.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule
`default_nettype wire

// *** rtl/pwcs_channel.sv ***
// Purpose: One PWM channel: start/cancel sequencing, on-delay, clamped pulse train.
// Assumes: Control and configuration come from logic on mclk; gate_input is a raw pin.
// Notes: cycle_instant is a one-cycle pulse at each bus cycle output instant.
// What this block does
// - An echo bit shows whether the software start request is pending.
// - Gate input may act as hardware enable; isochronous mode ignores that setting.
// - With both enables, start comes on the first gate rising edge after request.
// - Further gate rising edges during a running sequence change nothing.
// - Start launches on-delay and raises active flag; pulses follow while request holds.
// - Dropping the request aborts; active flag and output go low; restart needed.
// - The gate level is judged at the moment a sequence starts.
// - One setting gives both minimum pulse width and minimum pause.
// - A computed pulse below the minimum width gives no pulse that period.
// - A pulse above period minus minimum pause holds output on all period.
// - Time base scales period, minimum width and on-delay, 0.1 ms or 1 ms.
// - Per-mille format: width is value over 1000 times the period.
// - Analog format: width is value over 27648 times the period.
// - A new output value takes effect at the next output rising edge.
// - Isochronous mode uses the configured period and ignores runtime period values.
// - Short interface, non-isochronous: period is configured period times factor.
// - Long interface, non-isochronous: period is the runtime setpoint directly.
// - Isochronous mode has no on-delay; output starts at the first cycle instant after the request.
// - Isochronous output aligns to the cycle instant; period rounded to nearest fit.
// - Isochronous period and bus cycle always stand in an integer ratio.
// - Period factor 0 to 255 weighted one tenth scales the configured period.
// - Long interface: on-delay factor 0 to 255 weighted one tenth scales on-delay.
// - A new period setpoint takes effect at the next output rising edge.
`timescale 1ns/10ps
`default_nettype none
module pwcs_channel #(
  parameter int unsigned TICK_FINE_CYC = pwcs_pkg::TICK_FINE_CYC,
  parameter int unsigned TICK_COARSE_CYC = pwcs_pkg::TICK_COARSE_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration and cyclic control.
  input wire pwcs_pkg::pwcs_cfg_s cfg,
  input wire pwcs_pkg::pwcs_ctrl_s ctrl,
  // Pins and bus timing.
  input wire logic gate_input,
  input wire logic cycle_instant,
  // Feedback and actuator output.
  output pwcs_pkg::pwcs_stat_s stat
);

  // Factor scaling with one-tenth weight, saturated to the 16-bit range.
  function automatic logic [15:0] scale_tenth(input logic [15:0] base, input logic [7:0] fac);
    logic [23:0] prod;
    logic [23:0] quot;
    prod = base * fac;
    quot = prod / pwcs_pkg::FACTOR_DIV;
    scale_tenth = (quot > 24'(pwcs_pkg::COUNT_MAX)) ? pwcs_pkg::COUNT_MAX : quot[15:0];
  endfunction

  // Search span for a period below one bus cycle, in ticks either side of the request.
  localparam int unsigned FIT_SPAN = 64;

  // Nearest period in integer ratio with the bus cycle. Above one cycle the period is
  // rounded to a whole number of cycles; below one it must divide the cycle exactly.
  // A bounded search keeps the loop small; when it finds no divisor the period falls
  // back to one full cycle, which keeps the ratio integer at the cost of accuracy.
  function automatic logic [15:0] iso_fit(input logic [15:0] per, input logic [15:0] cyc);
    logic [16:0] num;
    logic [16:0] n;
    logic [32:0] prod;
    logic [16:0] lo;
    logic [16:0] hi;
    logic [15:0] best;
    logic found;
    num = 17'h00000;
    n = 17'h00000;
    prod = 33'h000000000;
    lo = 17'h00000;
    hi = 17'h00000;
    best = cyc;
    found = 1'b0;
    if (per == 16'h0000 || cyc == 16'h0000) begin
      iso_fit = (per == 16'h0000) ? 16'h0001 : per;
    end else if (per >= cyc) begin
      num = {1'b0, per} + {2'b00, cyc[15:1]};
      n = num / {1'b0, cyc};
      prod = n * cyc;
      // Rounding up overshoots the count range by one cycle at most, so step back one.
      if (prod > 33'(pwcs_pkg::COUNT_MAX)) begin
        prod = prod - {17'h00000, cyc};
      end
      iso_fit = prod[15:0];
    end else begin
      for (int unsigned k = 0; k <= FIT_SPAN; k++) begin
        lo = {1'b0, per} - 17'(k);
        hi = {1'b0, per} + 17'(k);
        if (!found && !lo[16] && (lo != 17'h00000) && (({1'b0, cyc} % lo) == 17'h00000)) begin
          best = lo[15:0];
          found = 1'b1;
        end
        if (!found && (hi <= {1'b0, cyc}) && (({1'b0, cyc} % hi) == 17'h00000)) begin
          best = hi[15:0];
          found = 1'b1;
        end
      end
      iso_fit = best;
    end
  endfunction

  // Pulse width from output value and period, clamped by the minimum width.
  function automatic logic [15:0] calc_width(input logic [15:0] val, input logic [15:0] per,
                                            input logic analog, input logic [15:0] minw);
    logic [15:0] full;
    logic [15:0] vclip;
    logic [31:0] prod;
    logic [15:0] raw;
    full = analog ? pwcs_pkg::ANALOG_FULL : pwcs_pkg::PERMILLE_FULL;
    vclip = (val > full) ? full : val;
    prod = vclip * per;
    raw = 16'(prod / {16'h0000, full});
    if (raw < minw) begin
      calc_width = 16'h0000;
    end else if ({1'b0, raw} > ({1'b0, per} - {1'b0, minw})) begin
      calc_width = per;
    end else begin
      calc_width = raw;
    end
  endfunction

  // Gate pin synchroniser and qualified level.
  logic g1_reg;
  logic g2_reg;
  logic g3_reg;
  logic gate_lvl_reg;
  logic gate_lvl_next;

  // Sequencer registers.
  pwcs_pkg::pwcs_state_e state_reg;
  pwcs_pkg::pwcs_state_e state_next;
  logic sw_prev_reg;
  logic armed_reg;
  logic armed_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] per_reg;
  logic [15:0] per_next;
  logic [15:0] wid_reg;
  logic [15:0] wid_next;
  logic [15:0] iso_per_reg;
  logic [15:0] iso_per_next;
  logic out_reg;
  logic out_next;
  logic echo_reg;
  logic tick;

  // Time-base ticks for all counts.
  pwcs_tick #(
    .FINE_CYC(TICK_FINE_CYC),
    .COARSE_CYC(TICK_COARSE_CYC)
  ) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .coarse_sel(cfg.time_base_coarse),
    .tick(tick)
  );

  // A gate change counts only once the second and third stages agree.
  assign gate_lvl_next = (g2_reg == g3_reg) ? g3_reg : gate_lvl_reg;
  wire gate_rise = gate_lvl_next & ~gate_lvl_reg;

  // Start decode.
  wire sw = ctrl.sw_start_request;
  wire sw_rise = sw & ~sw_prev_reg & ~ctrl.direct_override;
  wire use_gate = cfg.gate_input_role & ~cfg.iso_mode;
  wire start_go = (state_reg == pwcs_pkg::ST_IDLE) && sw && (armed_reg || sw_rise)
                  && (use_gate ? gate_rise : 1'b1);

  // Effective period for the next period start.
  wire [15:0] per_short = scale_tenth(cfg.period_param, ctrl.period_factor);
  wire [15:0] per_sel_raw = cfg.iso_mode ? iso_per_reg
                          : (cfg.long_if ? ctrl.period_setpoint : per_short);
  wire [15:0] per_sel = (per_sel_raw == 16'h0000) ? 16'h0001 : per_sel_raw;
  wire [15:0] wid_sel = calc_width(ctrl.output_value, per_sel, cfg.fmt_analog, cfg.min_width);

  // Effective on-delay; isochronous operation has none.
  wire [15:0] dly_long = scale_tenth(cfg.on_delay_param, ctrl.on_delay_factor);
  wire [15:0] dly_sel = cfg.long_if ? dly_long : cfg.on_delay_param;
  wire dly_zero = cfg.iso_mode || (dly_sel == 16'h0000);

  // Period boundary: the only place value and period are reloaded.
  wire run_enter = (state_next == pwcs_pkg::ST_RUN) && (state_reg != pwcs_pkg::ST_RUN);
  wire per_wrap = (state_reg == pwcs_pkg::ST_RUN) && tick && (cnt_reg + 16'h0001 >= per_reg);
  wire period_load = run_enter || (per_wrap && sw);

  // Arming remembers a qualified request edge until the sequence starts.
  assign armed_next = sw && (armed_reg || sw_rise) && (state_reg == pwcs_pkg::ST_IDLE) && !start_go;
  assign iso_per_next = start_go ? iso_fit(cfg.period_param, cfg.bus_cycle_ticks) : iso_per_reg;

  // State sequencing.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pwcs_pkg::ST_IDLE: begin
        if (start_go) begin
          if (cfg.iso_mode) begin
            state_next = pwcs_pkg::ST_SYNC;
          end else if (dly_zero) begin
            state_next = pwcs_pkg::ST_RUN;
          end else begin
            state_next = pwcs_pkg::ST_DELAY;
          end
        end
      end
      pwcs_pkg::ST_DELAY: begin
        if (tick && (cnt_reg + 16'h0001 >= dly_sel)) begin
          state_next = pwcs_pkg::ST_RUN;
        end
      end
      pwcs_pkg::ST_SYNC: begin
        if (cycle_instant) begin
          state_next = pwcs_pkg::ST_RUN;
        end
      end
      pwcs_pkg::ST_RUN: begin
        state_next = pwcs_pkg::ST_RUN;
      end
      default: begin
        state_next = pwcs_pkg::ST_IDLE;
      end
    endcase
    if (!sw) begin
      state_next = pwcs_pkg::ST_IDLE;
    end
  end

  // Tick counter shared by on-delay and period.
  always_comb begin
    cnt_next = cnt_reg;
    if (start_go || period_load || state_next == pwcs_pkg::ST_IDLE) begin
      cnt_next = 16'h0000;
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Period and width latch at each period start.
  assign per_next = period_load ? per_sel : per_reg;
  assign wid_next = period_load ? wid_sel : wid_reg;

  // Output is high for the first wid ticks of each period.
  assign out_next = (state_next == pwcs_pkg::ST_RUN)
                    && (cnt_next < wid_next);

  // Gate synchroniser.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      g1_reg <= 1'b0;
      g2_reg <= 1'b0;
      g3_reg <= 1'b0;
      gate_lvl_reg <= 1'b0;
    end else begin
      g1_reg <= gate_input;
      g2_reg <= g1_reg;
      g3_reg <= g2_reg;
      gate_lvl_reg <= gate_lvl_next;
    end
  end

  // Sequencer state.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= pwcs_pkg::ST_IDLE;
      sw_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      iso_per_reg <= pwcs_pkg::PERIOD_DEFAULT;
    end else begin
      state_reg <= state_next;
      sw_prev_reg <= sw;
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      iso_per_reg <= iso_per_next;
    end
  end

  // Period, width and feedback registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      per_reg <= 16'h0001;
      wid_reg <= 16'h0000;
      out_reg <= 1'b0;
      echo_reg <= 1'b0;
    end else begin
      per_reg <= per_next;
      wid_reg <= wid_next;
      out_reg <= out_next;
      echo_reg <= sw;
    end
  end

  // Feedback outputs, all from flip-flops except the active flag, which is decoded from state_reg.
  assign stat.sequence_active_flag = (state_reg != pwcs_pkg::ST_IDLE);
  assign stat.start_request_echo = echo_reg;
  assign stat.gate_level = gate_lvl_reg;
  assign stat.pulse_out = out_reg;

  // Checks on the sequencer.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  echo_tracks_a: assert property (sw ##1 sw |-> stat.start_request_echo)
    else $error("echo low while start request held");
  cancel_forces_a: assert property (!sw |=> !stat.sequence_active_flag && !stat.pulse_out)
    else $error("active flag or output left high after cancel");
  start_raises_a: assert property (start_go |=> stat.sequence_active_flag)
    else $error("sequence start did not raise active flag");
  gate_needed_a: assert property ((state_reg == pwcs_pkg::ST_IDLE) && use_gate && !gate_rise
                                   |=> (state_reg == pwcs_pkg::ST_IDLE))
    else $error("sequence started without a gate edge");
  run_kept_a: assert property ((state_reg == pwcs_pkg::ST_RUN) && sw
                                ##1 sw |-> (state_reg == pwcs_pkg::ST_RUN))
    else $error("running sequence disturbed while request held");
  iso_nodelay_a: assert property (start_go && cfg.iso_mode
                                   |=> (state_reg == pwcs_pkg::ST_SYNC) || !sw)
    else $error("isochronous start went through an on-delay");
  min_clamp_a: assert property ((state_reg == pwcs_pkg::ST_RUN)
                                 |-> (wid_reg == 16'h0000) || (wid_reg >= cfg.min_width))
    else $error("pulse shorter than minimum width");
  value_hold_a: assert property ((state_reg == pwcs_pkg::ST_RUN) && !period_load
                                  |=> $stable(wid_reg) && $stable(per_reg))
    else $error("width or period changed inside a period");
  short_period_a: assert property (period_load && !cfg.iso_mode && !cfg.long_if
                                    && (per_short != 16'h0000) |=> per_reg == $past(per_short))
    else $error("short interface period not param times factor");
  iso_ratio_a: assert property ((state_reg == pwcs_pkg::ST_RUN) && cfg.iso_mode
                                 && (cfg.bus_cycle_ticks != 16'h0000)
                                 |-> ((per_reg < cfg.bus_cycle_ticks)
                                      ? ((cfg.bus_cycle_ticks % per_reg) == 16'h0000)
                                      : ((per_reg % cfg.bus_cycle_ticks) == 16'h0000)))
    else $error("isochronous period not in integer ratio with the cycle");
  iso_period_a: assert property (period_load && cfg.iso_mode
                                  |=> per_reg == $past(iso_per_reg))
    else $error("isochronous period taken from the control interface");
  long_period_a: assert property (period_load && !cfg.iso_mode && cfg.long_if
                                   && (ctrl.period_setpoint != 16'h0000)
                                   |=> per_reg == $past(ctrl.period_setpoint))
    else $error("long interface period not the setpoint");
  sync_wait_a: assert property ((state_reg == pwcs_pkg::ST_SYNC) && !cycle_instant
                                 |=> (state_reg != pwcs_pkg::ST_RUN) && !stat.pulse_out)
    else $error("isochronous output began before the cycle instant");

endmodule
`default_nettype wire

// *** testbench/pwcs_actuator_model.sv ***
// Purpose: Far-side model: bus cycle instant source and actuator pulse meter.
// Assumes: One clock; the cycle instant repeats every CYCLE_CYC clocks.
// Notes: Widths are counted in clocks between edges seen on the actuator line.
`timescale 1ns/10ps
`default_nettype none
module pwcs_actuator_model #(
  parameter int unsigned CYCLE_CYC = 20
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Actuator line and bus timing.
  input wire logic pulse_out,
  output logic cycle_instant,
  // Measured figures.
  output logic [15:0] high_cyc,
  output logic [15:0] period_cyc,
  output logic [7:0] rises
);
  logic [15:0] cyc_reg;
  logic [15:0] since_reg;
  logic last_reg;

  // The bus cycle runs free from reset, as a real bus master does.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= 16'h0000;
      cycle_instant <= 1'b0;
    end else begin
      cyc_reg <= (cyc_reg == 16'(CYCLE_CYC - 1)) ? 16'h0000 : cyc_reg + 16'h0001;
      cycle_instant <= (cyc_reg == 16'(CYCLE_CYC - 1));
    end
  end

  // One counter restarts at each rise, so fall and next rise give width and period.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 1'b0;
      since_reg <= 16'h0000;
      high_cyc <= 16'h0000;
      period_cyc <= 16'h0000;
      rises <= 8'h00;
    end else begin
      last_reg <= pulse_out;
      since_reg <= (pulse_out && !last_reg) ? 16'h0001 : since_reg + 16'h0001;
      if (pulse_out && !last_reg) begin
        period_cyc <= since_reg;
        rises <= rises + 8'h01;
      end
      if (!pulse_out && last_reg) begin
        high_cyc <= since_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/test_pwcs_channel.sv ***
// Purpose: Self-checking bench for one PWM channel, driven as the controller would.
// Assumes: Base ticks shortened to 2 and 4 clocks; bus cycle of 10 fine ticks.
// Notes: Inputs change on rising edges; results are read on falling edges.
`timescale 1ns/10ps
`default_nettype none
module test_pwcs_channel;
  localparam int TF = 2;
  localparam int TC = 4;
  logic mclk;
  logic arst_n;
  pwcs_pkg::pwcs_cfg_s cfg;
  pwcs_pkg::pwcs_ctrl_s ctrl;
  logic gate_input;
  logic cycle_instant;
  pwcs_pkg::pwcs_stat_s stat;
  logic [15:0] high_cyc;
  logic [15:0] period_cyc;
  logic [7:0] rises;
  logic [7:0] r;
  int failures;
  int n_tests;
  int cyc;

  pwcs_channel #(.TICK_FINE_CYC(TF), .TICK_COARSE_CYC(TC)) pwcs_channel_i (
    .mclk(mclk), .arst_n(arst_n), .cfg(cfg), .ctrl(ctrl), .gate_input(gate_input),
    .cycle_instant(cycle_instant), .stat(stat));
  pwcs_actuator_model #(.CYCLE_CYC(10 * TF)) pwcs_actuator_model_i (
    .mclk(mclk), .arst_n(arst_n), .pulse_out(stat.pulse_out), .cycle_instant(cycle_instant),
    .high_cyc(high_cyc), .period_cyc(period_cyc), .rises(rises));

  // Free-running clock at 25 MHz.
  always #20 mclk = ~mclk;

  // A hung wait must not stall the run forever, so a cycle ceiling cuts it short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end

  task automatic bad(input string msg);
    failures++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic check_bit(input string what, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) bad(what);
  endtask
  task automatic check_val(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) bad(what);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wait_rises(input int n, input int lim);
    logic [7:0] goal;
    int k;
    goal = rises + 8'(n);
    k = 0;
    while (rises !== goal && k < lim) begin
      @(negedge mclk);
      k++;
    end
    n_tests++;
    if (rises !== goal) bad("output edge missing");
  endtask
  task automatic prep(input pwcs_pkg::pwcs_cfg_s c, input logic [15:0] v, input logic [7:0] pf,
                      input logic [15:0] ps, input logic [7:0] df);
    @(posedge mclk);
    cfg <= c;
    ctrl <= '{1'b0, 1'b0, v, pf, ps, df};
  endtask
  // The controller raises the request with the override set to the given level.
  task automatic start(input logic ov);
    @(posedge mclk);
    ctrl.direct_override <= ov;
    ctrl.sw_start_request <= 1'b1;
  endtask
  task automatic stop();
    @(posedge mclk);
    ctrl.sw_start_request <= 1'b0;
    ctrl.direct_override <= 1'b0;
    gate_input <= 1'b0;
    step(3);
  endtask
  task automatic final_report();
    $display("comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset for two clocks, then one test per behaviour.
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    cfg = '0;
    ctrl = '0;
    gate_input = 1'b0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    step(2);
    check_val("reset status", 16'(stat), 16'h0000);
    @(posedge mclk);
    arst_n <= 1'b1;
    prep('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0000, 16'h0000, 16'h000a},
         16'h01f4, 8'h0a, 16'h0000, 8'h00);
    start(1'b0);
    step(3);
    check_bit("active flag", stat.sequence_active_flag, 1'b1);
    check_bit("echo", stat.start_request_echo, 1'b1);
    wait_rises(3, 300);
    check_val("period", period_cyc, 16'(20 * TF));
    check_val("width", high_cyc, 16'(10 * TF));
    wait_rises(1, 100);
    @(posedge mclk);
    ctrl.output_value <= 16'h00fa;
    while (stat.pulse_out === 1'b1) step(1);
    step(1);
    check_val("old value kept", high_cyc, 16'(10 * TF));
    wait_rises(2, 200);
    check_val("new value", high_cyc, 16'(5 * TF));
    @(posedge mclk);
    ctrl.period_factor <= 8'h05;
    wait_rises(3, 200);
    check_val("new factor", period_cyc, 16'(10 * TF));
    stop();
    check_val("cancel", 16'(stat), 16'h0000);
    $display("test short_permille done");
    prep('{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0014, 16'h0000, 16'h0000, 16'h000a},
         16'h3600, 8'h0a, 16'h0000, 8'h00);
    start(1'b0);
    wait_rises(3, 600);
    check_val("coarse period", period_cyc, 16'(20 * TC));
    check_val("analog width", high_cyc, 16'(10 * TC));
    stop();
    $display("test coarse_analog done");
    // Values 150 and 850 sit exactly on the minimum pulse and minimum pause, 3 ticks.
    for (int i = 0; i < 2; i++) begin
      prep('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0003, 16'h0000, 16'h000a},
           (i == 0) ? 16'h0096 : 16'h0352, 8'h0a, 16'h0000, 8'h00);
      start(1'b0);
      wait_rises(3, 300);
      check_val("edge width", high_cyc, 16'(((i == 0) ? 3 : 17) * TF));
      stop();
    end
    prep(cfg, 16'h0064, 8'h0a, 16'h0000, 8'h00);
    start(1'b0);
    step(2);
    r = rises;
    step(200);
    check_val("short pulse dropped", 16'(rises), 16'(r));
    stop();
    prep(cfg, 16'h0384, 8'h0a, 16'h0000, 8'h00);
    start(1'b0);
    wait_rises(1, 100);
    r = rises;
    step(200);
    check_val("full on edges", 16'(rises), 16'(r));
    check_bit("full on level", stat.pulse_out, 1'b1);
    stop();
    $display("test clamping done");
    start(1'b1);
    step(10);
    check_bit("override start", stat.sequence_active_flag, 1'b0);
    check_bit("override echo", stat.start_request_echo, 1'b1);
    stop();
    $display("test override done");
    prep('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0014, 16'h0000, 16'h0000, 16'h000a},
         16'h01f4, 8'h0a, 16'h0000, 8'h00);
    start(1'b0);
    step(20);
    check_bit("gate low", stat.sequence_active_flag, 1'b0);
    @(posedge mclk);
    gate_input <= 1'b1;
    step(8);
    check_bit("gate edge", stat.sequence_active_flag, 1'b1);
    check_bit("gate level", stat.gate_level, 1'b1);
    wait_rises(2, 200);
    @(posedge mclk);
    gate_input <= 1'b0;
    step(6);
    @(posedge mclk);
    gate_input <= 1'b1;
    // The very next period holds the gate edge, so a restart would stretch it.
    wait_rises(1, 200);
    check_val("gate ignored", period_cyc, 16'(20 * TF));
    check_val("gate ignored width", high_cyc, 16'(10 * TF));
    check_bit("still active", stat.sequence_active_flag, 1'b1);
    stop();
    $display("test gate done");
    prep('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0000, 16'h0014, 16'h000a},
         16'h01f4, 8'h00, 16'h000a, 8'h05);
    start(1'b0);
    step(12);
    check_bit("delay active", stat.sequence_active_flag, 1'b1);
    check_bit("delay output", stat.pulse_out, 1'b0);
    // Ten scaled ticks end within sixteen clocks of here; an unscaled delay would not.
    wait_rises(1, 16);
    wait_rises(2, 100);
    check_val("setpoint period", period_cyc, 16'(10 * TF));
    check_val("setpoint width", high_cyc, 16'(5 * TF));
    stop();
    start(1'b0);
    step(8);
    stop();
    check_bit("abort in delay", stat.sequence_active_flag, 1'b0);
    r = rises;
    step(60);
    check_val("no late pulse", 16'(rises), 16'(r));
    $display("test long_delay done");
    // Bus cycle of 10 ticks: a 16-tick request gives 20, a 6-tick one gives 5.
    // The second pass uses the long interface, whose setpoint must be ignored too.
    for (int i = 0; i < 2; i++) begin
      prep('{1'b1, (i == 1), 1'b1, 1'b0, 1'b0, (i == 0) ? 16'h0010 : 16'h0006, 16'h0000,
             16'h0032, 16'h000a}, 16'h01f4, 8'h0a, 16'h0000, 8'h00);
      start(1'b0);
      wait_rises(1, 50);
      wait_rises(2, 200);
      check_val("iso period", period_cyc, 16'(((i == 0) ? 20 : 5) * TF));
      @(posedge mclk);
      ctrl.period_factor <= 8'h28;
      ctrl.period_setpoint <= 16'h0028;
      wait_rises(3, 300);
      check_val("iso factor", period_cyc, 16'(((i == 0) ? 20 : 5) * TF));
      stop();
    end
    $display("test isochronous done");
    final_report();
  end
endmodule
`default_nettype wire
